// ==== core/imp_pkg.sv ====
/*
 * Package for the interrupt mode and priority selection block.
 * Holds source counts, field widths, mode encodings and vector numbering constants.
 * Assumes one 25 MHz system clock shared by every user of these names.
 */
package imp_pkg;
	localparam int NUM_SRC = 8;
	localparam int LVL_W = 3;
	localparam int VEC_W = 8;
	localparam int SRC_W = 3;
	localparam logic [LVL_W-1:0] LVL_MAX = 3'h7;
	localparam logic [LVL_W-1:0] LVL_ZERO = 3'h0;
	localparam logic [VEC_W-1:0] NMI_VECTOR = 8'h07;
	localparam logic [VEC_W-1:0] SRC_VECTOR_BASE = 8'h10;
	localparam logic [VEC_W-1:0] VEC_ZERO = 8'h00;
	localparam logic [1:0] MODE_0 = 2'h0;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam real CLK_PERIOD_NS = 40.0;
	typedef enum logic [1:0] {IMP_IDLE, IMP_HOLD} imp_state_t;
endpackage

// ==== core/imp_select.sv ====
/*
 * Interrupt acceptance and priority selection: mode 0 single-bit masking or mode 2
 * eight-level masking, fixed default order tie break, vector output and mask update.
 * Assumes the CPU core pulses ack at an instruction boundary and stacks registers itself.
 * Assumes every input is synchronous to core_clk_in and that the CPU applies the next_*
 * values to its own mask and trace bits in the cycle that exc_start_out is high.
 * Request inputs are levels that the sources hold until they are serviced.
 */
`timescale 1ns/1ps

// Overview of operation
// - Non-maskable request accepted always, except during reset or hardware standby.
// - Each source has an enable; disabled sources never request or arbitrate.
// - Mode bits: 00 selects mode 0, 10 selects mode 2; low bit one prohibited.
// - Mode 0: mask bit clear passes all enabled; set passes only non-maskable.
// - Mode 2: pick highest level source whose level strictly exceeds mask level.
// - Mode 2: eight levels per source, compared against three-bit mask field.
// - Equal winning levels resolved by fixed order, lowest source index first.
// - Selected request yields its final priority and a vector number.
// - Losing requests stay pending and compete again later.
// - Mode 2: user mask bit still forced to one on acceptance.
// - Mode 2 acceptance clears trace bit, loads mask level, seven for non-maskable.
// - Mode 0 acceptance sets the mask bit to one.
// - Exception handling starts only after the current instruction completes.
module imp_select
#(
	parameter int NUM_SRC = imp_pkg::NUM_SRC
)
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic standby_in,
	input wire logic nmi_req_in,
	input wire logic [NUM_SRC-1:0] src_req_in,
	input wire logic [NUM_SRC-1:0] src_enable_in,
	input wire logic [NUM_SRC*imp_pkg::LVL_W-1:0] source_priority_level_in,
	input wire logic ctrl_mode_hi_in,
	input wire logic ctrl_mode_lo_in,
	input wire logic user_mask_bit_in,
	input wire logic [imp_pkg::LVL_W-1:0] mask_level_field_in,
	input wire logic trace_bit_in,
	input wire logic insn_end_in,
	input wire logic ack_in,
	output logic irq_valid_out,
	output logic irq_is_nmi_out,
	output logic [imp_pkg::VEC_W-1:0] vector_out,
	output logic [imp_pkg::LVL_W-1:0] win_level_out,
	output logic exc_start_out,
	output logic next_user_mask_bit_out,
	output logic [imp_pkg::LVL_W-1:0] next_mask_level_out,
	output logic next_trace_bit_out,
	output logic mode_error_out
);
	import imp_pkg::*;

	// Levels travel packed, three bits per source, source 0 in the lowest bits.
	// The search below reads them through one function so that a change of width
	// or order touches a single place.

	// Level of one source pulled from the packed level bus
	function automatic logic [LVL_W-1:0] lvl_of(input logic [NUM_SRC*LVL_W-1:0] lv, input int i);
		lvl_of = lv[i*LVL_W +: LVL_W];
	endfunction

	imp_state_t state;
	wire [1:0] mode_sel = {ctrl_mode_hi_in, ctrl_mode_lo_in};
	wire mode2 = (mode_sel == MODE_2);
	wire mode0 = (mode_sel == MODE_0);
	wire nmi_ok = nmi_req_in && !standby_in;
	wire [NUM_SRC-1:0] active = src_req_in & src_enable_in;

	// Priority search; strict greater keeps the lowest index on ties
	logic [LVL_W-1:0] best_lvl;
	logic [SRC_W-1:0] best_idx;
	logic best_any;
	always_comb
	begin
		best_lvl = LVL_ZERO;
		best_idx = SRC_W'(0);
		best_any = 1'b0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (active[i] && (!best_any || (mode2 && lvl_of(source_priority_level_in, i) > best_lvl)))
			begin
				best_any = 1'b1;
				best_lvl = mode2 ? lvl_of(source_priority_level_in, i) : LVL_ZERO;
				best_idx = SRC_W'(i);
			end
		end
	end

	// Acceptance gating per mode.
	// A prohibited mode (low bit set) makes both mode flags false, so no source can
	// pass; the non-maskable request still gets through as it must.
	wire src_pass0 = mode0 && best_any && !user_mask_bit_in;
	wire src_pass2 = mode2 && best_any && (best_lvl > mask_level_field_in);
	wire cand = nmi_ok || src_pass0 || src_pass2;
	wire [VEC_W-1:0] cand_vec = nmi_ok ? NMI_VECTOR : SRC_VECTOR_BASE + VEC_W'(best_idx);
	wire [LVL_W-1:0] cand_lvl = nmi_ok ? LVL_MAX : best_lvl;
	wire [LVL_W-1:0] new_mask = mode2 ? cand_lvl : mask_level_field_in;
	wire new_trace = mode2 ? 1'b0 : trace_bit_in;

	// Strobes shared by the output registers; results update only while idle,
	// so the CPU sees a frozen answer from acceptance until its acknowledge
	wire in_idle = (state == IMP_IDLE);
	wire accept = in_idle && cand && insn_end_in;
	wire release_hold = (state == IMP_HOLD) && ack_in;

	// Sequencer: idle until acceptance, hold until the CPU acknowledges
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			state <= IMP_IDLE;
		else
		begin
			case (state)
				IMP_IDLE:
				begin
					if (accept)
						state <= IMP_HOLD;
				end
				IMP_HOLD:
				begin
					// Sources not taken remain in src_req_in and compete again
					if (ack_in)
						state <= IMP_IDLE;
				end
				default:
					state <= IMP_IDLE;
			endcase
		end
	end

	// Candidate present; dropped on the acknowledge edge
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			irq_valid_out <= 1'b0;
		else if (release_hold)
			irq_valid_out <= 1'b0;
		else if (in_idle)
			irq_valid_out <= cand;
	end

	// Winner is the non-maskable request
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			irq_is_nmi_out <= 1'b0;
		else if (in_idle)
			irq_is_nmi_out <= nmi_ok;
	end

	// Vector number of the winner
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			vector_out <= VEC_ZERO;
		else if (in_idle)
			vector_out <= cand_vec;
	end

	// Final priority level of the winner
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			win_level_out <= LVL_ZERO;
		else if (in_idle)
			win_level_out <= cand_lvl;
	end

	// One-cycle start pulse after the accepting edge
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			exc_start_out <= 1'b0;
		else
			exc_start_out <= accept;
	end

	// Single mask bit is set on every acceptance, in both modes
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			next_user_mask_bit_out <= 1'b0;
		else if (in_idle)
			next_user_mask_bit_out <= 1'b1;
	end

	// Mask level to load: winner level in mode 2, unchanged in mode 0
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			next_mask_level_out <= LVL_ZERO;
		else if (in_idle)
			next_mask_level_out <= new_mask;
	end

	// Trace bit to load: cleared in mode 2, unchanged in mode 0
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			next_trace_bit_out <= 1'b0;
		else if (in_idle)
			next_trace_bit_out <= new_trace;
	end

	// Flags a prohibited mode setting; tracks the low mode bit each clock
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			mode_error_out <= 1'b0;
		else
			mode_error_out <= ctrl_mode_lo_in;
	end
endmodule

// ==== dv/imp_select_assertions.sv ====
/* Checker on the imp_select ports.
   Bound onto imp_select; one clock, synchronous reset. */
`timescale 1ns/1ps
module imp_checker
import imp_pkg::*;
(
	input wire logic core_clk_in, sys_rst_in, standby_in, nmi_req_in, ctrl_mode_hi_in, user_mask_bit_in,
	input wire logic insn_end_in, ack_in, irq_is_nmi_out, exc_start_out, next_user_mask_bit_out, next_trace_bit_out,
	input wire logic ctrl_mode_lo_in, mode_error_out,
	input wire logic [2:0] mask_level_field_in, win_level_out, next_mask_level_out,
	input wire logic [7:0] vector_out
);
	logic held, m2;
	wire idle = !exc_start_out && !held;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Hold spans start pulse to ack edge; mode kept as seen at acceptance
	always_ff @(posedge core_clk_in)
	begin
		held <= !sys_rst_in && !ack_in && !idle;
		m2 <= ctrl_mode_hi_in;
	end
	property p_nmi; idle && insn_end_in && nmi_req_in && !standby_in |=> vector_out == NMI_VECTOR; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi");
	property p_m0; idle && !ctrl_mode_hi_in && user_mask_bit_in && !nmi_req_in |=> !exc_start_out; endproperty
	a_m0: assert property (p_m0) else $error("mask bit");
	property p_lv; exc_start_out && m2 && !irq_is_nmi_out |-> win_level_out > $past(mask_level_field_in); endproperty
	a_lv: assert property (p_lv) else $error("level");
	property p_um; exc_start_out |-> next_user_mask_bit_out; endproperty
	a_um: assert property (p_um) else $error("mask set");
	property p_lw; exc_start_out && m2 |-> !next_trace_bit_out
		&& next_mask_level_out == (irq_is_nmi_out ? LVL_MAX : win_level_out); endproperty
	a_lw: assert property (p_lw) else $error("mask load");
	property p_in; idle && !insn_end_in |=> !exc_start_out; endproperty
	a_in: assert property (p_in) else $error("boundary");
	property p_pl; exc_start_out |=> !exc_start_out; endproperty
	a_pl: assert property (p_pl) else $error("pulse");
	property p_hd; !idle && !ack_in |=> $stable(vector_out) && $stable(win_level_out); endproperty
	a_hd: assert property (p_hd) else $error("hold");
	property p_me; !$past(sys_rst_in) |-> mode_error_out == $past(ctrl_mode_lo_in); endproperty
	a_me: assert property (p_me) else $error("mode error");
endmodule

// ==== dv/imp_cpu_model.sv ====
/* CPU model: acks each start pulse, alternately soon and late.
   Runs on the design clock. */
`timescale 1ns/1ps
module imp_cpu_model
(
	input wire logic clk_in,
	input wire logic exc_in,
	output logic ack_out = 1'b0
);
	logic [2:0] cnt = 3'h0;
	logic slow = 1'b0;
	// Counts down from the pulse and acks at the falling edge
	always @(negedge clk_in)
	begin
		ack_out <= cnt == 3'h1;
		cnt <= exc_in ? {slow, 2'h1} : cnt - {2'h0, |cnt};
		slow <= slow ^ exc_in;
	end
endmodule

// ==== dv/interrupt_mode_priority_select_tb_top.sv ====
/* Bench for imp_select acting as sources and CPU.
   Needs design, checker and CPU model compiled first. */
`timescale 1ns/1ps
module interrupt_mode_priority_select_tb_top;
	import imp_pkg::*;
	logic core_clk_in = 0, sys_rst_in = 1, standby_in = 0, nmi_req_in = 0, ctrl_mode_hi_in = 0, user_mask_bit_in = 0;
	logic insn_end_in = 0, ack_in, irq_valid_out, exc_start_out, ctrl_mode_lo_in = 0, trace_bit_in = 1, mode_error_out;
	logic [7:0] src_req_in = 0, vector_out, src_enable_in = 8'hdf;
	logic [23:0] source_priority_level_in = 0;
	logic [2:0] mask_level_field_in = 0;
	int fails = 0, check_count = 0, i;
	imp_select uut (.*, .irq_is_nmi_out(), .win_level_out(), .next_user_mask_bit_out(), .next_mask_level_out(),
		.next_trace_bit_out());
	imp_cpu_model cpu (.clk_in(core_clk_in), .exc_in(exc_start_out), .ack_out(ack_in));
	initial forever #20 core_clk_in = ~core_clk_in;
	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Counts one comparison and reports a mismatch
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Applies one pattern at a boundary, compares the vector, waits out the hold
	task automatic run(input logic n, input logic [7:0] r, input logic [23:0] l, input logic h, u,
		input logic [2:0] m, input logic [7:0] ev);
		@(negedge core_clk_in);
		{nmi_req_in, src_req_in, source_priority_level_in, ctrl_mode_hi_in, user_mask_bit_in} = {n, r, l, h, u};
		{mask_level_field_in, insn_end_in} = {m, 1'b1};
		for (i = 0; i < 5 && exc_start_out !== 1'b1; i++)
			@(negedge core_clk_in);
		check("vector", ev, (exc_start_out === 1'b1) ? vector_out : VEC_ZERO);
		{nmi_req_in, src_req_in} = 9'h000;
		for (i = 0; i < 9 && irq_valid_out !== 1'b0; i++)
			@(negedge core_clk_in);
		if (i == 9)
		begin
			fails++;
			print_verdict();
		end
		else
			$display("test %h done", ev);
	endtask
	// Reset for 12 cycles, then one pattern per case
	initial
	begin
		repeat (12) @(negedge core_clk_in);
		sys_rst_in = 0;
		standby_in = 1;
		run(1, 0, 0, 0, 0, 0, VEC_ZERO);
		standby_in = 0;
		run(1, 8'h04, 0, 0, 1, 0, NMI_VECTOR);
		run(0, 8'h04, 0, 0, 0, 0, 8'h12);
		run(0, 8'h04, 0, 0, 1, 0, VEC_ZERO);
		run(0, 8'h20, 0, 0, 0, 0, VEC_ZERO);
		@(negedge core_clk_in);
		{insn_end_in, src_req_in} = {1'b0, 8'h04};
		repeat (3) @(negedge core_clk_in);
		check("early start", 8'h00, {7'h00, exc_start_out});
		check("pending", 8'h01, {7'h00, irq_valid_out});
		run(0, 8'h04, 0, 0, 0, 0, 8'h12);
		ctrl_mode_lo_in = 1;
		run(0, 8'h04, 0, 0, 0, 0, VEC_ZERO);
		check("mode error", 8'h01, {7'h00, mode_error_out});
		ctrl_mode_lo_in = 0;
		run(0, 8'h12, 24'h5018, 1, 1, 3'h3, 8'h14);
		run(0, 8'h10, 24'h5018, 1, 0, 3'h5, VEC_ZERO);
		run(0, 8'h48, 24'h18_0c00, 1, 0, 3'h5, 8'h13);
		run(0, 8'h40, 24'h18_0c00, 1, 0, 3'h5, 8'h16);
		run(1, 0, 0, 1, 0, 3'h7, NMI_VECTOR);
		print_verdict();
	end
endmodule
bind imp_select imp_checker chk_i (.*);
